// >>> pkg/adcs_pkg.sv
/*
  Constants and types shared by the conversion sequencer and its SAR engine.
  Assumes a single system clock domain and the special function register port.
*/
package adcs_pkg;

  // ****************************************
  // Register addresses
  // ****************************************
  localparam logic [7:0] ADDR_POS_SELECT = 8'hBB;
  localparam logic [7:0] ADDR_NEG_SELECT = 8'hBA;
  localparam logic [7:0] ADDR_CONFIG     = 8'hBC;
  localparam logic [7:0] ADDR_RESULT_LO  = 8'hBD;
  localparam logic [7:0] ADDR_RESULT_HI  = 8'hBE;
  localparam logic [7:0] ADDR_CONTROL    = 8'hE8;

  // ****************************************
  // Control register fields
  // ****************************************
  localparam int CTL_JUSTIFY_BIT = 0;
  localparam int CTL_MODE_LSB    = 1;
  localparam int CTL_BUSY_BIT    = 4;
  localparam int CTL_DONE_BIT    = 5;
  localparam int CTL_TRACK_BIT   = 6;
  localparam int CTL_ENABLE_BIT  = 7;

  // ****************************************
  // Config and select fields, result width
  // ****************************************
  localparam int DIV_LSB  = 3;
  localparam int DIV_W    = 5;
  localparam int CHAN_W   = 5;
  localparam int RES_BITS = 10;

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [7:0]        RST_CONTROL = 8'h00;
  localparam logic [DIV_W-1:0]  RST_DIVIDER = 5'h1F;
  localparam logic [CHAN_W-1:0] RST_POS_SEL = 5'h00;
  localparam logic [CHAN_W-1:0] RST_NEG_SEL = 5'h1F;
  localparam logic [CHAN_W-1:0] CODE_GROUND = 5'h1F;
  localparam logic [15:0]       RST_RESULT  = 16'h0000;

  // ****************************************
  // Timing
  // ****************************************
  localparam logic [1:0] TRACK_SAR_CLOCKS = 2'h3;

  // ****************************************
  // Start mode and sequencer state codes
  // ****************************************
  typedef enum logic [2:0] {
    ADCS_START_SOFT   = 3'b000,
    ADCS_START_TMR0   = 3'b001,
    ADCS_START_TMR2   = 3'b010,
    ADCS_START_TMR1   = 3'b011,
    ADCS_START_PIN    = 3'b100,
    ADCS_START_TMR3   = 3'b101,
    ADCS_START_NONE_6 = 3'b110,
    ADCS_START_NONE_7 = 3'b111
  } adcs_start_e;

  typedef enum logic [1:0] {
    ADCS_IDLE  = 2'b00,
    ADCS_TRACK = 2'b01,
    ADCS_CONV  = 2'b10
  } adcs_state_e;

endpackage

// >>> rtl/adcs_sar_engine.sv
/*
  SAR clock divider and bit-by-bit successive approximation engine.
  Assumes sample_code comes from the analog front end on the system clock.
*/
`timescale 1ns/1ps

module adcs_sar_engine
  import adcs_pkg::*;
#(
  parameter int BITS = RES_BITS
) (
  input  wire logic              clk,
  input  wire logic              resetn,
  input  wire logic              run,
  input  wire logic [DIV_W-1:0]  divider,
  input  wire logic              start,
  input  wire logic [BITS-1:0]   sample_code,
  output logic                   sar_tick,
  output logic                   done,
  output logic [BITS-1:0]        code
);

  if (BITS < 2 || BITS > 16) begin : g_bits_check
    $error("BITS out of range");
  end

  logic [DIV_W-1:0]     div_cnt;
  logic [DIV_W-1:0]     next_div_cnt;
  logic                 next_sar_tick;
  logic [BITS-1:0]      hold;
  logic [BITS-1:0]      next_hold;
  logic [BITS-1:0]      next_code;
  logic [BITS-1:0]      bit_mask;
  logic [BITS-1:0]      next_bit_mask;
  logic                 next_done;
  logic [BITS-1:0]      trial;

  // ****************************************
  // Divider and approximation
  // ****************************************
  always_comb begin
    next_div_cnt  = '0;
    next_sar_tick = 1'b0;
    next_hold     = hold;
    next_code     = code;
    next_bit_mask = bit_mask;
    next_done     = 1'b0;
    trial         = code | bit_mask;
    if (run) begin
      if (div_cnt >= divider) begin
        next_sar_tick = 1'b1; // R1
      end else begin
        next_div_cnt = div_cnt + 1'b1; // R1
      end
    end
    if (!run) begin
      next_bit_mask = '0;
    end else if (start) begin
      next_hold     = sample_code;
      next_code     = '0;
      next_bit_mask = {1'b1, {(BITS-1){1'b0}}}; // R16
    end else if (sar_tick && bit_mask != '0) begin
      if (trial <= hold) begin
        next_code = trial;
      end
      next_bit_mask = bit_mask >> 1;
      next_done     = bit_mask[0];
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      div_cnt  <= '0;
      sar_tick <= 1'b0;
      hold     <= '0;
      code     <= '0;
      bit_mask <= '0;
      done     <= 1'b0;
    end else begin
      div_cnt  <= next_div_cnt;
      sar_tick <= next_sar_tick;
      hold     <= next_hold;
      code     <= next_code;
      bit_mask <= next_bit_mask;
      done     <= next_done;
    end
  end

endmodule

// >>> rtl/adcs_sequencer.sv
/*
  Conversion sequencer of a 10-bit SAR converter: start selection, tracking,
  busy and completion flags, result formatting and input select registers.
  Assumes a byte-wide special function register port and timer overflow
  pulses on the system clock; the start pin is asynchronous.
*/
`timescale 1ns/1ps

// How it works
// R1 - Converter clock is system clock divided by divider field plus one.
// R2 - Software keeps the conversion rate at or below 200 ksps.
// R3 - Start mode field picks software, timer 0/1/2/3 or pin trigger.
// R4 - In software mode, writing one to busy starts a conversion.
// R5 - Busy is one for the whole conversion, zero when it ends.
// R6 - Busy falling edge sets done flag and interrupts when enabled.
// R7 - Result bytes are valid whenever the done flag is one.
// R8 - Timer 2/3 triggers use low overflow in 8-bit, high in 16-bit.
// R9 - Pin start mode converts on each rising edge of the start pin.
// R10 - Software makes the crossbar skip the shared start pin.
// R11 - Tracking mode zero tracks continuously except during conversion.
// R12 - Tracking mode one tracks three converter clocks after each start.
// R13 - Low-power pin mode tracks while pin low, converts on rising edge.
// R14 - Tracking shuts down during standby or sleep.
// R15 - Software allows tracking time after changing the input channel.
// R16 - Results have 10 bits of resolution.
// R17 - Temperature reading uses sensor against ground plus calibration.
// R18 - Positive select register holds a 5-bit input code at 0xBB.
// R19 - Converter runs only while enable is one, else shut down.
// R20 - Ground negative input is single-ended unsigned, else signed differential.
// R21 - Justify bit zero right-justifies, one left-justifies, padding per mode.
// R22 - Triggers during a conversion are ignored; busy stays set.
module adcs_sequencer
  import adcs_pkg::*;
(
  input  wire logic                clk,
  input  wire logic                resetn,
  input  wire logic [7:0]          sfr_addr,
  input  wire logic                sfr_wr,
  input  wire logic [7:0]          sfr_wdata,
  input  wire logic                sfr_rd,
  output logic [7:0]               sfr_rdata,
  input  wire logic                tmr0_ovf,
  input  wire logic                tmr1_ovf,
  input  wire logic                tmr2_low_ovf,
  input  wire logic                tmr2_high_ovf,
  input  wire logic                tmr2_16bit,
  input  wire logic                tmr3_low_ovf,
  input  wire logic                tmr3_high_ovf,
  input  wire logic                tmr3_16bit,
  input  wire logic                external_start_input,
  input  wire logic                standby,
  input  wire logic                irq_enable,
  input  wire logic [RES_BITS-1:0] sample_code,
  output logic                     conversion_irq,
  output logic                     track_enable,
  output logic                     converter_on,
  output logic [CHAN_W-1:0]        positive_input_code,
  output logic [CHAN_W-1:0]        negative_input_code
);

  logic              converter_enable;
  logic              tracking_mode_select;
  logic              conversion_done_flag;
  logic              result_left_justify;
  adcs_start_e       start_mode_select;
  logic [DIV_W-1:0]  conv_clock_divider;
  logic [15:0]       result_word;
  adcs_state_e       state;
  logic [1:0]        track_cnt;
  logic              pin_meta;
  logic              pin_sync;
  logic              pin_prev;
  logic              conversion_busy;
  logic              pin_rise;
  logic              trigger;
  logic              sw_start;
  logic              wr_ctl;
  logic              sar_start;
  logic              sar_tick;
  logic              sar_done;
  logic [RES_BITS-1:0] sar_code;
  logic              single_ended;

  logic              next_converter_enable;
  logic              next_tracking_mode_select;
  logic              next_conversion_done_flag;
  logic              next_result_left_justify;
  adcs_start_e       next_start_mode_select;
  logic [DIV_W-1:0]  next_conv_clock_divider;
  logic [CHAN_W-1:0] next_positive_input_code;
  logic [CHAN_W-1:0] next_negative_input_code;
  logic [15:0]       next_result_word;
  adcs_state_e       next_state;
  logic [1:0]        next_track_cnt;
  logic              next_conversion_irq;
  logic              next_track_enable;
  logic              next_converter_on;
  logic [7:0]        next_sfr_rdata;

  // ****************************************
  // Start pin synchroniser
  // ****************************************
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pin_meta <= 1'b0;
      pin_sync <= 1'b0;
      pin_prev <= 1'b0;
    end else begin
      pin_meta <= external_start_input;
      pin_sync <= pin_meta;
      pin_prev <= pin_sync;
    end
  end

  assign pin_rise = pin_sync & ~pin_prev; // R9

  // ****************************************
  // Trigger selection
  // ****************************************
  assign wr_ctl   = sfr_wr && (sfr_addr == ADDR_CONTROL);
  assign sw_start = wr_ctl && sfr_wdata[CTL_BUSY_BIT]; // R4

  always_comb begin
    unique case (start_mode_select) // R3
      ADCS_START_SOFT: trigger = sw_start; // R4
      ADCS_START_TMR0: trigger = tmr0_ovf;
      ADCS_START_TMR2: trigger = tmr2_16bit ? tmr2_high_ovf : tmr2_low_ovf; // R8
      ADCS_START_TMR1: trigger = tmr1_ovf;
      ADCS_START_PIN:  trigger = pin_rise; // R9
      ADCS_START_TMR3: trigger = tmr3_16bit ? tmr3_high_ovf : tmr3_low_ovf; // R8
      default:         trigger = 1'b0;
    endcase
  end

  assign conversion_busy = (state != ADCS_IDLE); // R5
  assign single_ended    = (negative_input_code == CODE_GROUND); // R20

  // ****************************************
  // Conversion sequence
  // ****************************************
  always_comb begin
    next_state          = state;
    next_track_cnt      = track_cnt;
    sar_start           = 1'b0;
    next_conversion_irq = 1'b0;
    next_result_word    = result_word;
    if (!converter_enable) begin
      next_state     = ADCS_IDLE; // R19
      next_track_cnt = '0;
    end else begin
      unique case (state)
        ADCS_IDLE: begin
          if (trigger) begin // R22
            if (tracking_mode_select && start_mode_select != ADCS_START_PIN) begin
              next_state     = ADCS_TRACK; // R12
              next_track_cnt = '0;
            end else begin
              next_state = ADCS_CONV; // R11 R13
              sar_start  = 1'b1;
            end
          end
        end
        ADCS_TRACK: begin
          if (sar_tick) begin
            if (track_cnt == TRACK_SAR_CLOCKS - 2'h1) begin
              next_state = ADCS_CONV; // R12
              sar_start  = 1'b1;
            end else begin
              next_track_cnt = track_cnt + 2'h1;
            end
          end
        end
        ADCS_CONV: begin
          if (sar_done) begin
            next_state          = ADCS_IDLE; // R5
            next_conversion_irq = irq_enable; // R6
            if (single_ended) begin
              next_result_word = result_left_justify ? {sar_code, 6'h00}
                                 : {6'h00, sar_code}; // R20 R21
            end else begin
              next_result_word = result_left_justify ?
                {~sar_code[RES_BITS-1], sar_code[RES_BITS-2:0], 6'h00} :
                {{6{~sar_code[RES_BITS-1]}}, ~sar_code[RES_BITS-1],
                 sar_code[RES_BITS-2:0]}; // R20 R21
            end
          end
        end
        default: begin
          next_state = ADCS_IDLE;
        end
      endcase
    end
  end

  // ****************************************
  // Analog control outputs
  // ****************************************
  always_comb begin
    next_converter_on = converter_enable; // R19
    next_track_enable = 1'b0;
    if (converter_enable && !standby) begin // R14
      if (!tracking_mode_select) begin
        next_track_enable = (next_state == ADCS_IDLE); // R11
      end else if (start_mode_select == ADCS_START_PIN) begin
        next_track_enable = (next_state == ADCS_IDLE) && !pin_sync; // R13
      end else begin
        next_track_enable = (next_state == ADCS_TRACK); // R12
      end
    end
  end

  // ****************************************
  // Register writes
  // ****************************************
  always_comb begin
    next_converter_enable     = converter_enable;
    next_tracking_mode_select = tracking_mode_select;
    next_conversion_done_flag = conversion_done_flag;
    next_result_left_justify  = result_left_justify;
    next_start_mode_select    = start_mode_select;
    next_conv_clock_divider   = conv_clock_divider;
    next_positive_input_code  = positive_input_code;
    next_negative_input_code  = negative_input_code;
    if (wr_ctl) begin
      next_converter_enable     = sfr_wdata[CTL_ENABLE_BIT];
      next_tracking_mode_select = sfr_wdata[CTL_TRACK_BIT];
      next_conversion_done_flag = sfr_wdata[CTL_DONE_BIT];
      next_result_left_justify  = sfr_wdata[CTL_JUSTIFY_BIT];
      next_start_mode_select    = adcs_start_e'(sfr_wdata[CTL_MODE_LSB +: 3]);
    end
    if (sfr_wr && sfr_addr == ADDR_CONFIG) begin
      next_conv_clock_divider = sfr_wdata[DIV_LSB +: DIV_W]; // R1
    end
    if (sfr_wr && sfr_addr == ADDR_POS_SELECT) begin
      next_positive_input_code = sfr_wdata[CHAN_W-1:0]; // R18
    end
    if (sfr_wr && sfr_addr == ADDR_NEG_SELECT) begin
      next_negative_input_code = sfr_wdata[CHAN_W-1:0];
    end
    if (state == ADCS_CONV && sar_done && converter_enable) begin
      next_conversion_done_flag = 1'b1; // R6 R7
    end
  end

  // ****************************************
  // Register reads
  // ****************************************
  always_comb begin
    next_sfr_rdata = sfr_rdata;
    if (sfr_rd) begin
      unique case (sfr_addr)
        ADDR_CONTROL: begin
          next_sfr_rdata = {converter_enable, tracking_mode_select,
                            conversion_done_flag, conversion_busy,
                            start_mode_select, result_left_justify};
        end
        ADDR_CONFIG:     next_sfr_rdata = {conv_clock_divider, 3'h0};
        ADDR_POS_SELECT: next_sfr_rdata = {3'h0, positive_input_code}; // R18
        ADDR_NEG_SELECT: next_sfr_rdata = {3'h0, negative_input_code};
        ADDR_RESULT_LO:  next_sfr_rdata = result_word[7:0]; // R7
        ADDR_RESULT_HI:  next_sfr_rdata = result_word[15:8]; // R7
        default:         next_sfr_rdata = 8'h00;
      endcase
    end
  end

  // ****************************************
  // State registers
  // ****************************************
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      converter_enable     <= RST_CONTROL[CTL_ENABLE_BIT];
      tracking_mode_select <= RST_CONTROL[CTL_TRACK_BIT];
      conversion_done_flag <= RST_CONTROL[CTL_DONE_BIT];
      result_left_justify  <= RST_CONTROL[CTL_JUSTIFY_BIT];
      start_mode_select    <= ADCS_START_SOFT;
      conv_clock_divider   <= RST_DIVIDER;
      positive_input_code  <= RST_POS_SEL;
      negative_input_code  <= RST_NEG_SEL;
      result_word          <= RST_RESULT;
      state                <= ADCS_IDLE;
      track_cnt            <= 2'h0;
      conversion_irq       <= 1'b0;
      track_enable         <= 1'b0;
      converter_on         <= 1'b0;
      sfr_rdata            <= 8'h00;
    end else begin
      converter_enable     <= next_converter_enable;
      tracking_mode_select <= next_tracking_mode_select;
      conversion_done_flag <= next_conversion_done_flag;
      result_left_justify  <= next_result_left_justify;
      start_mode_select    <= next_start_mode_select;
      conv_clock_divider   <= next_conv_clock_divider;
      positive_input_code  <= next_positive_input_code;
      negative_input_code  <= next_negative_input_code;
      result_word          <= next_result_word;
      state                <= next_state;
      track_cnt            <= next_track_cnt;
      conversion_irq       <= next_conversion_irq;
      track_enable         <= next_track_enable;
      converter_on         <= next_converter_on;
      sfr_rdata            <= next_sfr_rdata;
    end
  end

  // ****************************************
  // SAR engine
  // ****************************************
  adcs_sar_engine #(
    .BITS        (RES_BITS) // R16
  ) u_sar (
    .clk         (clk),
    .resetn      (resetn),
    .run         (converter_enable),
    .divider     (conv_clock_divider),
    .start       (sar_start),
    .sample_code (sample_code),
    .sar_tick    (sar_tick),
    .done        (sar_done),
    .code        (sar_code)
  );

endmodule

// >>> tb/adcs_seq_asserts.sv
/*
  Port checker for the conversion sequencer.
  Assumes it is bound to adcs_sequencer on its single clock.
*/
`timescale 1ns/1ps

module adcs_seq_asserts
  import adcs_pkg::*;
(
  input wire logic              clk,
  input wire logic              resetn,
  input wire logic [7:0]        sfr_addr,
  input wire logic              sfr_wr,
  input wire logic [7:0]        sfr_wdata,
  input wire logic              sfr_rd,
  input wire logic [7:0]        sfr_rdata,
  input wire logic              standby,
  input wire logic              irq_enable,
  input wire logic              conversion_irq,
  input wire logic              track_enable,
  input wire logic              converter_on,
  input wire logic [CHAN_W-1:0] positive_input_code
);
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);

  logic [3:0] gap;
  logic [3:0] next_gap;

  // ****************************************
  // Cycles since the last completion
  // ****************************************
  always_comb begin
    next_gap = gap;
    if (conversion_irq)
      next_gap = 4'h0;
    else if (gap != 4'hF)
      next_gap = gap + 4'h1;
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn)
      gap <= 4'h0;
    else
      gap <= next_gap;
  end

  // ****************************************
  // Sequences and assertions
  // ****************************************
  sequence pos_wr_s;
    sfr_wr && sfr_addr == ADDR_POS_SELECT;
  endsequence
  sequence pos_rd_s;
    sfr_rd && !sfr_wr && sfr_addr == ADDR_POS_SELECT;
  endsequence
  sequence ctl_wr_s;
    sfr_wr && sfr_addr == ADDR_CONTROL;
  endsequence
  sequence off_s;
    !converter_on [*2];
  endsequence

  irq_one_cycle_a: assert property (conversion_irq |=> !conversion_irq)
    else $error("completion interrupt wider than one cycle");
  irq_gated_a: assert property (conversion_irq |-> irq_enable || $past(irq_enable))
    else $error("completion interrupt while disabled");
  conv_length_a: assert property (conversion_irq |-> gap >= 4'h9)
    else $error("conversion shorter than ten steps");
  hold_in_conv_a: assert property (conversion_irq |-> !$past(track_enable))
    else $error("tracking during conversion");
  standby_off_a: assert property (standby [*2] |-> !track_enable)
    else $error("tracking in standby");
  shutdown_quiet_a: assert property (off_s |-> !track_enable && !conversion_irq)
    else $error("activity while converter is off");
  enable_follow_a: assert property (ctl_wr_s |=> ##1
    {7'h00, converter_on} == ($past(sfr_wdata, 2) >> 7))
    else $error("converter on does not follow enable bit");
  pos_write_a: assert property (pos_wr_s |=>
    {3'h0, positive_input_code} == ($past(sfr_wdata) & 8'h1F))
    else $error("positive select not written");
  pos_read_a: assert property (pos_rd_s |=> sfr_rdata == {3'h0, positive_input_code})
    else $error("positive select read mismatch");
endmodule

bind adcs_sequencer adcs_seq_asserts i_adcs_seq_asserts (
  .clk                 (clk),
  .resetn              (resetn),
  .sfr_addr            (sfr_addr),
  .sfr_wr              (sfr_wr),
  .sfr_wdata           (sfr_wdata),
  .sfr_rd              (sfr_rd),
  .sfr_rdata           (sfr_rdata),
  .standby             (standby),
  .irq_enable          (irq_enable),
  .conversion_irq      (conversion_irq),
  .track_enable        (track_enable),
  .converter_on        (converter_on),
  .positive_input_code (positive_input_code)
);

// >>> tb/adcs_sequencer_tb.sv
/*
  Self-checking bench for the conversion sequencer.
  Assumes the checker is bound by its own file; one 40 MHz clock.
*/
`timescale 1ns/1ps

module adcs_sequencer_tb
  import adcs_pkg::*;
;
  logic       clk = 1'b0, resetn = 1'b0, sfr_wr = 1'b0, sfr_rd = 1'b0;
  logic       tmr0_ovf = 1'b0, tmr1_ovf = 1'b0, tmr2_low_ovf = 1'b0, tmr2_high_ovf = 1'b0;
  logic       tmr3_low_ovf = 1'b0, tmr3_high_ovf = 1'b0, tmr2_16bit = 1'b0, tmr3_16bit = 1'b0;
  logic       ext_pin = 1'b0, standby = 1'b0, irq_enable = 1'b0;
  logic [7:0] sfr_addr = 8'h00, sfr_wdata = 8'h00, sfr_rdata;
  logic [9:0] sample_code = 10'h000;
  logic       conversion_irq, track_enable, converter_on;
  logic [4:0] positive_input_code, negative_input_code;
  int         mismatches = 0, cmp_count = 0, irq_cnt = 0, cyc = 0;

  adcs_sequencer i_adcs_sequencer (
    .clk(clk), .resetn(resetn), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
    .sfr_wdata(sfr_wdata), .sfr_rd(sfr_rd), .sfr_rdata(sfr_rdata),
    .tmr0_ovf(tmr0_ovf), .tmr1_ovf(tmr1_ovf), .tmr2_low_ovf(tmr2_low_ovf),
    .tmr2_high_ovf(tmr2_high_ovf), .tmr2_16bit(tmr2_16bit),
    .tmr3_low_ovf(tmr3_low_ovf), .tmr3_high_ovf(tmr3_high_ovf),
    .tmr3_16bit(tmr3_16bit), .external_start_input(ext_pin), .standby(standby),
    .irq_enable(irq_enable), .sample_code(sample_code),
    .conversion_irq(conversion_irq), .track_enable(track_enable),
    .converter_on(converter_on), .positive_input_code(positive_input_code),
    .negative_input_code(negative_input_code)
  );

  // ****************************************
  // Clock and event counters
  // ****************************************
  always #12.5 clk = ~clk;
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (conversion_irq === 1'b1)
      irq_cnt <= irq_cnt + 1;
  end

  // ****************************************
  // Tasks and model
  // ****************************************
  task automatic close_out();
    $display("mismatches=%0d cmp_count=%0d", mismatches, cmp_count);
    if (mismatches == 0 && cmp_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic sfr_w(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    sfr_addr <= a;
    sfr_wdata <= d;
    sfr_wr <= 1'b1;
    @(posedge clk);
    sfr_wr <= 1'b0;
  endtask

  task automatic sfr_r(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    sfr_addr <= a;
    sfr_rd <= 1'b1;
    @(posedge clk);
    sfr_rd <= 1'b0;
    #1 d = sfr_rdata;
  endtask

  function automatic logic [15:0] model(logic [9:0] c, logic [4:0] neg, logic lj);
    logic [9:0] d;
    d = (neg == 5'h1F) ? c : {~c[9], c[8:0]};
    if (lj)
      return {d, 6'h00};
    return (neg == 5'h1F) ? {6'h00, d} : {{6{d[9]}}, d};
  endfunction

  // One conversion; twist retriggers in software mode or fires the unused timer byte
  task automatic conv(input int m, input logic tm, input logic twist);
    logic [7:0] ctl, v, hi, lo;
    logic [4:0] neg;
    logic [9:0] code;
    logic       bad;
    int         p, t0, n;
    p = $urandom_range(32, 20);
    bad = twist && (m == 2 || m == 5);
    code = 10'($urandom);
    neg = $urandom_range(1) ? 5'h1F : 5'($urandom_range(30));
    ctl = {1'b1, tm, 2'h0, 3'(m), 1'($urandom_range(1))};
    @(posedge clk);
    sample_code <= code;
    ext_pin <= 1'b0;
    irq_enable <= 1'($urandom_range(1));
    tmr2_16bit <= 1'($urandom_range(1));
    tmr3_16bit <= 1'($urandom_range(1));
    sfr_w(ADDR_CONFIG, {5'(p - 1), 3'h0});
    sfr_w(ADDR_NEG_SELECT, {3'h0, neg});
    sfr_w(ADDR_CONTROL, ctl);
    chk(16'(negative_input_code), 16'(neg));
    n = irq_cnt;
    t0 = cyc;
    @(posedge clk);
    case (m)
      0: sfr_wdata <= ctl | 8'h10;
      1: tmr0_ovf <= 1'b1;
      2: tmr2_high_ovf <= tmr2_16bit ^ bad;
      3: tmr1_ovf <= 1'b1;
      4: ext_pin <= 1'b1;
      default: tmr3_high_ovf <= tmr3_16bit ^ bad;
    endcase
    tmr2_low_ovf <= (m == 2) && !(tmr2_16bit ^ bad);
    tmr3_low_ovf <= (m == 5) && !(tmr3_16bit ^ bad);
    sfr_addr <= ADDR_CONTROL;
    sfr_wr <= (m == 0);
    @(posedge clk);
    {sfr_wr, tmr0_ovf, tmr1_ovf, tmr2_low_ovf, tmr2_high_ovf} <= 5'h00;
    {tmr3_low_ovf, tmr3_high_ovf} <= 2'h0;
    if (twist && m == 0)
      sfr_w(ADDR_CONTROL, ctl | 8'h10);
    sfr_r(ADDR_CONTROL, v);
    if (m != 4)
      chk(16'(v[4]), 16'(!bad));
    chk(16'(track_enable), 16'(bad ? !tm : tm && m != 4));
    for (int i = 0; i < 400 && !v[5]; i++)
      sfr_r(ADDR_CONTROL, v);
    t0 = cyc - t0;
    chk(16'(v[5:4]), bad ? 16'h0000 : 16'h0002);
    if (!bad) begin
      if (!v[5])
        close_out();
      chk(16'(irq_cnt - n), 16'(irq_enable));
      if (tm && m != 4)
        chk(16'(t0 >= 12 * p), 16'h0001);
      if (!tm && m == 0)
        chk(16'(t0 <= 11 * p + 8), 16'h0001);
      sfr_r(ADDR_RESULT_HI, hi);
      sfr_r(ADDR_RESULT_LO, lo);
      chk({hi, lo}, model(code, neg, ctl[0]));
    end
  endtask

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    logic [7:0] v, w;
    logic [7:0] ra [5];
    logic [7:0] rv [5];
    ra = '{ADDR_POS_SELECT, ADDR_NEG_SELECT, ADDR_CONFIG, ADDR_CONTROL, 8'h00};
    rv = '{8'h00, 8'h1F, 8'hF8, 8'h00, 8'h00};
    void'($urandom(55));
    repeat (12) @(posedge clk);
    resetn <= 1'b1;
    for (int i = 0; i < 5; i++) begin
      sfr_r(ra[i], v);
      chk({8'h00, v}, {8'h00, rv[i]});
    end
    for (int c = 0; c <= 10; c++) begin
      w = (c == 10) ? 8'hFF : 8'(c);
      sfr_w(ADDR_POS_SELECT, w);
      sfr_r(ADDR_POS_SELECT, v);
      chk({8'h00, v}, {8'h00, w & 8'h1F});
      chk(16'(positive_input_code), 16'(w & 8'h1F));
    end
    for (int k = 0; k < 24; k++)
      conv(k % 6, 1'(k / 12), 1'((k / 6) % 2));
    sfr_w(ADDR_CONTROL, 8'h80);
    repeat (3) @(posedge clk);
    chk(16'(track_enable), 16'h0001);
    standby <= 1'b1;
    repeat (3) @(posedge clk);
    chk(16'(track_enable), 16'h0000);
    standby <= 1'b0;
    sfr_w(ADDR_CONTROL, 8'h8C);
    sfr_w(ADDR_CONTROL, 8'h9C);
    sfr_r(ADDR_CONTROL, v);
    chk({8'h00, v}, 16'h008C);
    sfr_w(ADDR_CONTROL, 8'h00);
    sfr_w(ADDR_CONTROL, 8'h10);
    for (int i = 0; i < 20; i++)
      sfr_r(ADDR_CONTROL, v);
    chk({8'h00, v}, 16'h0000);
    chk(16'({converter_on, track_enable}), 16'h0000);
    close_out();
  end
endmodule
